// [adcs_ctrl.sv]
// Purpose: serial select/shift-clock/address front end and conversion sequencer
// Assumes: pins are asynchronous to core_clk; analog_code is a same-clock input
// Notes: results pass a small FIFO; a full FIFO holds end-of-conversion low
//
// Notes on behaviour
// - after select falls, ignore inputs for setup time plus two system clock edges
// - after select rises, stop taking address and shift clock within the guard time
// - 10-clock cycles work with select toggled or held low
// - toggled select allows 11 to 16 clocks; held low allows only 16
// - end-of-conversion drops after tenth rising edge, rises when conversion ends
// - select falling within 9 us of tenth falling edge aborts conversion
// - self-test channels 1011, 1100, 1101 give codes 512, 0, 1023
`timescale 1ns/100ps
module adcs_ctrl #(
	parameter int CONV_CYCLES = 5250,
	parameter int SYS_DIVIDE = 54
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input adcs_pkg::adcs_pins_t pins,
	input wire logic [adcs_pkg::RES_W-1:0] analog_code,
	output logic [adcs_pkg::ADDR_W-1:0] conv_chan,
	output adcs_pkg::adcs_outs_t outs
);
	import adcs_pkg::*;

	adcs_state_t st_q;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [1:0] prev_q;
	logic [7:0] sys_cnt_q;
	logic [9:0] guard_cnt_q;
	logic [1:0] tick_cnt_q;
	logic [4:0] bit_cnt_q;
	logic [4:0] fall_cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic [RES_W-1:0] shift_q;
	logic [RES_W-1:0] last_q;
	logic conv_q;
	logic res_v_q;
	logic pushed_q;
	logic [12:0] conv_cnt_q;
	logic abt_arm_q;
	logic [11:0] abt_cnt_q;
	logic [RES_W-1:0] res_code;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [RES_W-1:0] fifo_out_data;

	// ----------------------------------------
	// pin synchronisers and edge finding
	// ----------------------------------------
	// first stage is read only by the second stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			prev_q <= 2'h3;
		end else begin
			sync1_q <= {pins.cs_n, pins.io_clk, pins.addr};
			sync2_q <= sync1_q;
			prev_q <= sync2_q[2:1];
		end
	end

	wire cs_n_s = sync2_q[2];
	wire clk_s = sync2_q[1];
	wire addr_s = sync2_q[0];
	wire cs_fall_e = prev_q[1] && !cs_n_s;
	wire cs_rise_e = !prev_q[1] && cs_n_s;
	wire rise_e = !prev_q[0] && clk_s;
	wire fall_e = prev_q[0] && !clk_s;
	wire run = (st_q == ST_RUN);

	// ----------------------------------------
	// internal system clock as an enable
	// ----------------------------------------
	wire sys_tick = (sys_cnt_q == 8'(SYS_DIVIDE - 1));

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			sys_cnt_q <= '0;
		else
			sys_cnt_q <= sys_tick ? 8'h00 : sys_cnt_q + 8'h01;
	end

	// ----------------------------------------
	// select guard and state
	// ----------------------------------------
	wire setup_done = (guard_cnt_q == 10'(CS_SETUP_CYC));
	wire guard_done = setup_done && sys_tick && (tick_cnt_q == 2'(GUARD_TICKS - 1));
	wire push_fire = res_v_q && fifo_in_ready;
	wire abort_e = cs_fall_e && conv_q && abt_arm_q && (abt_cnt_q < 12'(ABORT_CYC));
	// restart while select stays low: one cycle after the push, so the new word is at the buffer head, or on the 16th fall if the push came earlier
	wire restart_e = run && ((pushed_q && (bit_cnt_q == START_EDGE || bit_cnt_q == MAX_EDGE))
		|| (fall_e && fall_cnt_q == MAX_EDGE - 5'h01 && !conv_q));
	wire load_e = (st_q == ST_GUARD && guard_done) || restart_e;

	// noise on select is rejected because any bounce restarts the guard
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q <= ST_OFF;
			guard_cnt_q <= '0;
			tick_cnt_q <= '0;
		end else if (cs_n_s) begin
			st_q <= ST_OFF;
			guard_cnt_q <= '0;
			tick_cnt_q <= '0;
		end else if (cs_fall_e || st_q == ST_OFF) begin
			st_q <= ST_GUARD;
			guard_cnt_q <= '0;
			tick_cnt_q <= '0;
		end else if (st_q == ST_GUARD) begin
			if (!setup_done)
				guard_cnt_q <= guard_cnt_q + 10'h001;
			else if (sys_tick)
				tick_cnt_q <= tick_cnt_q + 2'h1;
			if (guard_done)
				st_q <= ST_RUN;
		end
	end

	// ----------------------------------------
	// edge counters and address shift
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n || !run || load_e) begin
			bit_cnt_q <= '0;
			fall_cnt_q <= '0;
		end else begin
			if (rise_e && bit_cnt_q < MAX_EDGE)
				bit_cnt_q <= bit_cnt_q + 5'h01;
			if (fall_e && fall_cnt_q < MAX_EDGE)
				fall_cnt_q <= fall_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			addr_q <= ADDR_RST;
		else if (run && rise_e && bit_cnt_q < ADDR_BITS)
			addr_q <= {addr_q[ADDR_W-2:0], addr_s};
	end

	// ----------------------------------------
	// conversion timer, abort window, result
	// ----------------------------------------
	wire conv_start = run && rise_e && (bit_cnt_q == START_EDGE - 5'h01);
	wire conv_end = conv_q && !res_v_q && (conv_cnt_q == 13'(CONV_CYCLES - 1));

	always_ff @(posedge core_clk) begin
		if (!rst_n || abort_e) begin
			conv_q <= 1'b0;
			res_v_q <= 1'b0;
			conv_cnt_q <= '0;
		end else if (conv_start && !conv_q) begin
			conv_q <= 1'b1;
			conv_cnt_q <= '0;
		end else if (conv_end) begin
			res_v_q <= 1'b1;
		end else if (push_fire) begin
			conv_q <= 1'b0;
			res_v_q <= 1'b0;
		end else if (conv_q && !res_v_q) begin
			conv_cnt_q <= conv_cnt_q + 13'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			conv_chan <= ADDR_RST;
		else if (conv_start && !conv_q)
			conv_chan <= addr_q;
	end

	// push seen one cycle late; restarting on the push itself would reload the stale word
	always_ff @(posedge core_clk) begin
		pushed_q <= rst_n && push_fire;
	end

	// window opens on the tenth falling edge
	always_ff @(posedge core_clk) begin
		if (!rst_n || !conv_q) begin
			abt_arm_q <= 1'b0;
			abt_cnt_q <= '0;
		end else if (run && fall_e && fall_cnt_q == START_EDGE - 5'h01) begin
			abt_arm_q <= 1'b1;
			abt_cnt_q <= '0;
		end else if (abt_arm_q && abt_cnt_q < 12'(ABORT_CYC)) begin
			abt_cnt_q <= abt_cnt_q + 12'h001;
		end
	end

	// self-test channels bypass the analog path
	assign res_code = (conv_chan == CH_TEST_MID) ? CODE_MID :
		(conv_chan == CH_TEST_ZERO) ? CODE_ZERO :
		(conv_chan == CH_TEST_FULL) ? CODE_FULL : analog_code;

	// ----------------------------------------
	// result buffer
	// ----------------------------------------
	// a full buffer stalls the push, so end-of-conversion stays low meanwhile
	adcs_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(res_v_q),
		.in_ready(fifo_in_ready),
		.in_data(res_code),
		.out_valid(fifo_out_valid),
		.out_ready(load_e),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------
	// output shifter
	// ----------------------------------------
	// an empty buffer repeats the last result instead of sending stale zeros
	wire [RES_W-1:0] load_word = fifo_out_valid ? fifo_out_data : last_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			shift_q <= RES_RST;
			last_q <= RES_RST;
		end else if (load_e) begin
			shift_q <= load_word;
			last_q <= load_word;
		end else if (run && fall_e) begin
			shift_q <= {shift_q[RES_W-2:0], 1'b0};
		end
	end

	assign outs.data = shift_q[RES_W-1];
	assign outs.data_oe = run;
	assign outs.eoc = !conv_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_guard_two_ticks: assert property ((st_q == ST_GUARD) ##1 (st_q == ST_RUN) |->
		$past(sys_tick) && $past(tick_cnt_q) == 2'h1 && $past(guard_cnt_q) == 10'(CS_SETUP_CYC))
		else $error("guard left without two system ticks");
	a_cs_rise_stop: assert property (cs_rise_e |=> !outs.data_oe ##1 !run)
		else $error("inputs still accepted after select rise");
	a_ten_mode_restart: assert property (run && pushed_q && bit_cnt_q == START_EDGE |=>
		bit_cnt_q == 5'h00 && last_q == $past(fifo_out_data))
		else $error("10-clock cycle did not restart with the new result");
	a_sixteen_restart: assert property (restart_e && !pushed_q |-> fall_e && bit_cnt_q == MAX_EDGE)
		else $error("restart before sixteen rising edges were seen");
	a_eoc_drop: assert property (conv_start && !conv_q && !abort_e |=> !outs.eoc [*2])
		else $error("end-of-conversion did not drop on tenth rising edge");
	a_eoc_rise_cause: assert property ($rose(outs.eoc) |-> $past(push_fire) || $past(abort_e))
		else $error("end-of-conversion rose without result or abort");
	a_abort_clears: assert property (abort_e |=> outs.eoc && !res_v_q)
		else $error("abort did not end conversion");
	a_selftest_code: assert property (push_fire && conv_chan == CH_TEST_FULL |-> res_code == CODE_FULL)
		else $error("self-test code wrong");
	a_addr_shift: assert property (run && rise_e && bit_cnt_q < ADDR_BITS && !load_e |=>
		addr_q == {$past(addr_q[2:0]), $past(addr_s)})
		else $error("address bit not shifted");
	a_data_shift: assert property (run && fall_e && !load_e |=> outs.data == $past(shift_q[8]))
		else $error("data out did not advance on falling edge");

endmodule

// [adcs_pkg.sv]
// Purpose: shared constants and pin carriers for the serial converter control block
// Assumes: core clock of 250 MHz; all times in ns
// Notes: counts above 4096 cycles are repeated as top-level parameter defaults
package adcs_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CS_SETUP_NS = 1000;
	localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_NS = 21000;
	localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ABORT_NS = 9000;
	localparam int ABORT_CYC = ABORT_NS / CLK_PERIOD_NS;
	localparam int SYS_DIV = 54; // internal system clock divider
	localparam int GUARD_TICKS = 2; // falling edges of the system clock

	// ----------------------------------------
	// transfer shape
	// ----------------------------------------
	localparam int RES_W = 10;
	localparam int ADDR_W = 4;
	localparam logic [4:0] ADDR_BITS = 5'h04;
	localparam logic [4:0] START_EDGE = 5'h0a;
	localparam logic [4:0] MAX_EDGE = 5'h10;
	localparam int FIFO_DEPTH = 4;

	// ----------------------------------------
	// self-test channels and reset values
	// ----------------------------------------
	localparam logic [3:0] CH_TEST_MID = 4'hb;
	localparam logic [3:0] CH_TEST_ZERO = 4'hc;
	localparam logic [3:0] CH_TEST_FULL = 4'hd;
	localparam logic [9:0] CODE_MID = 10'h200;
	localparam logic [9:0] CODE_ZERO = 10'h000;
	localparam logic [9:0] CODE_FULL = 10'h3ff;
	localparam logic [9:0] RES_RST = 10'h000;
	localparam logic [3:0] ADDR_RST = 4'h0;

	typedef struct packed {
		logic cs_n;
		logic io_clk;
		logic addr;
	} adcs_pins_t;

	typedef struct packed {
		logic data;
		logic data_oe;
		logic eoc;
	} adcs_outs_t;

	typedef enum logic [1:0] {ST_OFF, ST_GUARD, ST_RUN} adcs_state_t;

endpackage

// [adcs_fifo.sv]
// Purpose: small result FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: head word comes straight from the storage flops
`timescale 1ns/100ps
module adcs_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// ----------------------------------------
	// flags: extra pointer bit tells full from empty
	// ----------------------------------------
	assign out_valid = (wptr_q != rptr_q);
	assign in_ready = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
	assign out_data = mem_q[rptr_q[AW-1:0]];

	// pointers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
		end
	end

	// storage needs no reset; nothing reads a slot before it is written
	always_ff @(posedge core_clk) begin
		if (push)
			mem_q[wptr_q[AW-1:0]] <= in_data;
	end

endmodule

// [adcs_host.sv]
// Purpose: host serial port model driving select, shift clock and address
// Assumes: pins change on core_clk falling edges; shift clock phases of 80 ns
// Notes: shift clock idles low between frames; data sampled late in each high phase
`timescale 1ns/100ps
module adcs_host (
	input wire logic core_clk,
	output adcs_pkg::adcs_pins_t pins,
	input adcs_pkg::adcs_outs_t outs
);
	import adcs_pkg::*;

	// ----------------------------------------
	// pin timing
	// ----------------------------------------
	initial begin
		pins = '{1'b1, 1'b0, 1'b0};
	end

	// half a shift clock period
	task automatic half();
		repeat (20) @(negedge core_clk);
	endtask

	// ----------------------------------------
	// one transfer cycle
	// ----------------------------------------
	// early pulses land inside the guard on purpose, to be ignored
	task automatic xfer(input logic [3:0] ch, input int n, input logic keep, input logic early,
		output logic [15:0] word, output logic oe0, output logic eoc_lo);
		int i;
		word = '0;
		eoc_lo = 1'b0;
		@(negedge core_clk);
		if (pins.cs_n) begin
			pins.cs_n = 1'b0;
			for (i = 0; i < 8 && early; i++) begin
				pins.io_clk = ~pins.io_clk;
				pins.addr = 1'b1;
				half();
			end
			repeat (300) @(negedge core_clk);
		end else begin
			for (i = 0; i < 2000 && outs.eoc !== 1'b1; i++) @(negedge core_clk);
			repeat (10) @(negedge core_clk);
		end
		oe0 = outs.data_oe;
		// exactly n pulses, each rise 160 ns after the last
		for (i = 0; i < n; i++) begin
			pins.addr = (i < 4) ? ch[3 - i] : i[0];
			half();
			pins.io_clk = 1'b1;
			half();
			word[15 - i] = outs.data;
			if (i == 9) eoc_lo = (outs.eoc === 1'b0);
			pins.io_clk = 1'b0;
		end
		half();
		if (!keep) pins.cs_n = 1'b1;
	endtask
endmodule

// [adcs_ctrl_bench.sv]
// Purpose: self-checking bench for the serial converter control block
// Assumes: shortened conversion and system clock divider
// Notes: each cycle returns the previous result; the first returns zero
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module adcs_ctrl_bench;
	import adcs_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int CONV = 200;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	adcs_pins_t pins;
	adcs_outs_t outs;
	logic [3:0] conv_chan;
	logic [9:0] analog_code = '0;
	logic [9:0] prev = RES_RST;
	int num_errors = 0;
	int comparisons = 0;

	always #2 core_clk = ~core_clk;

	// analog source follows the selected channel
	always @(negedge core_clk) analog_code <= {conv_chan, 6'h15};

	adcs_ctrl #(.CONV_CYCLES(CONV), .SYS_DIVIDE(4)) adcs_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
		.pins(pins), .analog_code(analog_code), .conv_chan(conv_chan), .outs(outs));
	adcs_host adcs_host_i (.core_clk(core_clk), .pins(pins), .outs(outs));

	// ----------------------------------------
	// shared cycle and expectations
	// ----------------------------------------
	function automatic logic [9:0] code_of(input logic [3:0] c);
		case (c)
			4'hb: return 10'h200;
			4'hc: return 10'h000;
			4'hd: return 10'h3ff;
			default: return {c, 6'h15};
		endcase
	endfunction

	// an aborted cycle leaves the last sent word to repeat
	task automatic run(input logic [3:0] ch, input int n, input logic keep, input logic early, input logic abrt);
		logic [15:0] w;
		logic oe0;
		logic el;
		int i;
		adcs_host_i.xfer(ch, n, keep, early, w, oe0, el);
		`CHK("word", {prev, 6'h00}, w)
		`CHK("oe_on", 1'b1, oe0)
		`CHK("eoc_low", 1'b1, el)
		`CHK("chan", ch, conv_chan)
		if (!keep) begin
			repeat (8) @(negedge core_clk);
			`CHK("oe_off", 1'b0, outs.data_oe)
		end
		if (!abrt) begin
			for (i = 0; i < 1000 && outs.eoc !== 1'b1; i++) @(negedge core_clk);
			`CHK("eoc_high", 1'b1, outs.eoc)
			prev = code_of(ch);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_lengths();
		for (int n = 10; n <= 16; n++) run(4'(n - 10), n, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_selftest();
		for (int c = 11; c <= 14; c++) run(4'(c), 10, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_guard();
		run(4'h7, 12, 1'b0, 1'b1, 1'b0);
	endtask

	// select held low: 10-clock then 16-clock cycles
	task automatic t_held();
		run(4'h8, 10, 1'b1, 1'b0, 1'b0);
		run(4'h9, 10, 1'b1, 1'b0, 1'b0);
		run(4'ha, 16, 1'b1, 1'b0, 1'b0);
		run(4'he, 16, 1'b1, 1'b0, 1'b0);
		run(4'hf, 16, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_abort();
		run(4'h5, 10, 1'b0, 1'b0, 1'b1);
		run(4'h6, 10, 1'b0, 1'b0, 1'b0);
		run(4'h3, 10, 1'b0, 1'b0, 1'b0);
	endtask

	// result queue seen from the pins: empty after reset sends the reset word,
	// the 16th fall pops the new result, and the next frame repeats it from an empty queue
	task automatic t_fifo();
		run(4'h1, 10, 1'b0, 1'b0, 1'b0);
		`CHK("fifo_chan", 4'h1, conv_chan)
		`CHK("fifo_oe_idle", 1'b0, outs.data_oe)
		run(4'h2, 16, 1'b0, 1'b0, 1'b0);
		`CHK("fifo_eoc_idle", 1'b1, outs.eoc)
		`CHK("fifo_oe_off", 1'b0, outs.data_oe)
		run(4'h3, 10, 1'b0, 1'b0, 1'b0);
		`CHK("fifo_repeat_chan", 4'h3, conv_chan)
		`CHK("fifo_eoc_done", 1'b1, outs.eoc)
	endtask

	// ----------------------------------------
	// sequence and verdict
	// ----------------------------------------
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_fifo();
		t_lengths();
		t_selftest();
		t_guard();
		t_held();
		t_abort();
		test_done();
	end

	// about 23 cycles of 0.9k clocks each, with fourfold margin
	initial begin
		#350000;
		num_errors++;
		test_done();
	end
endmodule
